// ### tape_ctl_pkg.sv
`default_nettype none
package tape_ctl_pkg;
  // ************************************************************
  // Timing
  // ************************************************************
  localparam int CLK_NS = 20;
  localparam int SEL_DLY_NS = 5000;
  localparam int SEL_DLY_CYC = (SEL_DLY_NS + CLK_NS - 1) / CLK_NS;
  localparam int BRK_TMO_NS = 17000;
  localparam int BRK_TMO_CYC = BRK_TMO_NS / CLK_NS;
  localparam int WORD_NS = 133500;
  localparam int LINES_PER_WORD = 4;
  localparam int LINE_CYC = WORD_NS / (LINES_PER_WORD * CLK_NS);
  localparam logic [8:0] SEL_DLY_CNT = 9'(SEL_DLY_CYC);
  localparam logic [9:0] BRK_TMO_CNT = 10'(BRK_TMO_CYC);
  localparam logic [10:0] LINE_CNT = 11'(LINE_CYC);

  // ************************************************************
  // Break locations, field 0
  // ************************************************************
  localparam logic [11:0] TRANSFER_WORD_COUNT_ADDR = 12'hFEC;
  localparam logic [11:0] TRANSFER_CURRENT_ADDRESS_ADDR = 12'hFED;

  // ************************************************************
  // First status word fields
  // ************************************************************
  localparam int SRA_UNIT_LSB = 9;
  localparam int SRA_REV = 8;
  localparam int SRA_GO = 7;
  localparam int SRA_MODE = 6;
  localparam int SRA_FN_LSB = 3;
  localparam int SRA_IE = 2;
  localparam int SRA_CLR_ERR = 1;
  localparam int SRA_CLR_DONE = 0;
  localparam logic [11:0] SRA_RST = 12'h000;

  localparam logic [2:0] FN_MOVE = 3'h0;
  localparam logic [2:0] FN_SEARCH = 3'h1;
  localparam logic [2:0] FN_RDATA = 3'h2;
  localparam logic [2:0] FN_RALL = 3'h3;
  localparam logic [2:0] FN_WDATA = 3'h4;
  localparam logic [2:0] FN_WALL = 3'h5;
  localparam logic [2:0] FN_WTM = 3'h6;
  localparam logic [2:0] FN_UNUSED = 3'h7;

  // ************************************************************
  // Error bits and mark codes
  // ************************************************************
  localparam int ERR_N = 5;
  localparam int ERR_MARK = 0;
  localparam int ERR_EOT = 1;
  localparam int ERR_SEL = 2;
  localparam int ERR_PAR = 3;
  localparam int ERR_TIM = 4;
  localparam logic [5:0] MK_CODE_END = 6'h01;
  localparam logic [5:0] MK_CODE_BLOCK = 6'h02;
  localparam logic [5:0] MK_CODE_DATA = 6'h04;
  localparam logic [5:0] MK_CODE_FINAL = 6'h05;
  localparam logic [5:0] MK_CODE_CHECK = 6'h06;
  localparam logic [5:0] MK_CODE_GAP_F = 6'h08;
  localparam logic [5:0] MK_CODE_GAP_R = 6'h09;
  localparam logic [5:0] PAR_GOOD = 6'h3F;

  typedef enum logic [2:0] {MK_GAP, MK_BLOCK, MK_DATA, MK_FINAL, MK_CHECK, MK_END, MK_BAD}
    mark_class_e;
  typedef enum logic [1:0] {BK_IDLE, BK_WC, BK_CA, BK_XFER} brk_state_e;
endpackage
`default_nettype wire

// ### mark_decode.sv
`default_nettype none
module mark_decode
  import tape_ctl_pkg::*;
(
  input wire logic [5:0] mark_code,
  input wire logic suppress,
  output mark_class_e mark_class
);
  always_comb
  begin
    case (mark_code)
      MK_CODE_END: mark_class = MK_END;
      MK_CODE_BLOCK: mark_class = MK_BLOCK;
      MK_CODE_DATA: mark_class = MK_DATA;
      MK_CODE_FINAL: mark_class = MK_FINAL;
      MK_CODE_CHECK: mark_class = MK_CHECK;
      MK_CODE_GAP_F: mark_class = MK_GAP;
      MK_CODE_GAP_R: mark_class = MK_GAP;
      default: mark_class = MK_BAD;
    endcase
    // Moving tape sees only the end zone
    if (suppress && mark_class != MK_END)
    begin
      mark_class = MK_GAP;
    end
  end
endmodule
`default_nettype wire

// ### tape_block_transfer_control.sv
`default_nettype none
module tape_block_transfer_control
  import tape_ctl_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic load_first_status_command,
  input wire logic [11:0] bus_output_lines,
  input wire logic done_clear,
  input wire logic fault_clear,
  input wire logic [7:0] unit_match,
  input wire logic [7:0] write_lock,
  input wire logic timing_mark_write_mode,
  input wire logic mark_stb,
  input wire logic [5:0] mark_code,
  input wire logic line_stb,
  input wire logic [2:0] tape_rdata,
  input wire logic brk_ack,
  input wire logic [11:0] brk_rdata,
  output logic [2:0] unit_sel,
  output logic tape_go,
  output logic tape_rev,
  output logic tape_write,
  output logic [2:0] tape_wdata,
  output logic timing_track_out,
  output logic data_request_flag,
  output logic [11:0] brk_addr,
  output logic brk_incr,
  output logic brk_we,
  output logic [11:0] brk_wdata,
  output logic operation_done_flag,
  output logic fault_flag,
  output logic mark_err,
  output logic eot_err,
  output logic sel_err,
  output logic par_err,
  output logic tim_err,
  output logic count_limited_mode,
  output logic irq
);
  // ************************************************************
  // Declarations
  // ************************************************************
  logic [2:0] function_code_bits;
  logic ie_r;
  logic [8:0] sel_cnt_r;
  logic [3:0] match_cnt;
  logic [10:0] gen_cnt_r;
  logic [1:0] gen_ln_r;
  logic gen_line_r;
  logic mark_evt;
  logic line_evt;
  logic wtm_fn;
  mark_class_e dec_class;
  mark_class_e cls_r;
  logic [1:0] lcnt_r;
  logic [11:0] rsh_r;
  logic [11:0] wbuf_r;
  logic [11:0] cur_word;
  logic word_done;
  logic reading;
  logic writing;
  logic data_cls;
  logic in_block_r;
  logic [5:0] par_r;
  logic [5:0] par_nxt;
  logic count_overflow;
  logic rd_req;
  logic wr_req;
  brk_state_e brk_r;
  logic [9:0] tmo_r;
  logic [11:0] xfer_word_r;
  logic [11:0] data_addr_r;
  logic xfer_end;
  logic done_set;
  logic done_clr;
  logic [ERR_N-1:0] err_set;
  logic [ERR_N-1:0] err_r;
  logic err_clr;

  // ************************************************************
  // Function decode
  // ************************************************************
  assign reading = function_code_bits == FN_SEARCH || function_code_bits == FN_RDATA
                   || function_code_bits == FN_RALL;
  assign writing = function_code_bits == FN_WDATA || function_code_bits == FN_WALL
                   || function_code_bits == FN_WTM;
  assign wtm_fn = function_code_bits == FN_WTM && tape_go;
  assign data_cls = cls_r == MK_DATA || cls_r == MK_FINAL;

  mark_decode u_mark_decode (
    .mark_code(mark_code),
    .suppress(function_code_bits == FN_MOVE),
    .mark_class(dec_class)
  );

  // ************************************************************
  // First status word
  // ************************************************************
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      unit_sel <= SRA_RST[SRA_UNIT_LSB +: 3];
      tape_rev <= SRA_RST[SRA_REV];
      count_limited_mode <= SRA_RST[SRA_MODE];
      function_code_bits <= SRA_RST[SRA_FN_LSB +: 3];
      ie_r <= SRA_RST[SRA_IE];
    end
    else if (load_first_status_command)
    begin
      unit_sel <= bus_output_lines[SRA_UNIT_LSB +: 3];
      tape_rev <= bus_output_lines[SRA_REV];
      count_limited_mode <= bus_output_lines[SRA_MODE];
      function_code_bits <= bus_output_lines[SRA_FN_LSB +: 3];
      ie_r <= bus_output_lines[SRA_IE];
    end
  end

  // Motion stops on any error but parity
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      tape_go <= SRA_RST[SRA_GO];
    else if (|(err_set & ~(ERR_N'(1) << ERR_PAR)))
      tape_go <= 1'b0;
    else if (load_first_status_command)
      tape_go <= bus_output_lines[SRA_GO];
  end

  // ************************************************************
  // Select check
  // ************************************************************
  always_comb
  begin
    match_cnt = 4'h0;
    for (int i = 0; i < 8; i++)
      match_cnt = match_cnt + {3'h0, unit_match[i]};
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      sel_cnt_r <= 9'h000;
    else if (load_first_status_command)
      sel_cnt_r <= SEL_DLY_CNT;
    else if (sel_cnt_r != 9'h000)
      sel_cnt_r <= sel_cnt_r - 9'h001;
  end

  // ************************************************************
  // Line timing; the timing-mark function makes its own clock
  // ************************************************************
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      gen_cnt_r <= 11'h000;
      gen_ln_r <= 2'h0;
      gen_line_r <= 1'b0;
      timing_track_out <= 1'b0;
    end
    else if (!wtm_fn)
    begin
      gen_cnt_r <= 11'h000;
      gen_ln_r <= 2'h0;
      gen_line_r <= 1'b0;
    end
    else
    begin
      gen_line_r <= gen_cnt_r == LINE_CNT - 11'h001;
      if (gen_cnt_r == LINE_CNT - 11'h001)
      begin
        gen_cnt_r <= 11'h000;
        gen_ln_r <= gen_ln_r + 2'h1;
        timing_track_out <= ~timing_track_out;
      end
      else
        gen_cnt_r <= gen_cnt_r + 11'h001;
    end
  end

  // Slot mark precedes its first line by one cycle
  assign mark_evt = wtm_fn ? (gen_cnt_r == LINE_CNT - 11'h001 && gen_ln_r == 2'h0)
                           : mark_stb && tape_go;
  assign line_evt = wtm_fn ? gen_line_r : line_stb && tape_go;
  assign word_done = line_evt && lcnt_r == 2'h3;
  assign cur_word = reading ? {rsh_r[8:0], tape_rdata} : wbuf_r;
  assign par_nxt = par_r ^ cur_word[11:6] ^ cur_word[5:0];

  // ************************************************************
  // Word assembly and disassembly
  // ************************************************************
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cls_r <= MK_GAP;
      lcnt_r <= 2'h0;
      rsh_r <= 12'h000;
      in_block_r <= 1'b0;
    end
    else if (mark_evt)
    begin
      cls_r <= wtm_fn ? MK_DATA : dec_class;
      lcnt_r <= 2'h0;
      in_block_r <= dec_class == MK_DATA || dec_class == MK_FINAL || dec_class == MK_CHECK;
    end
    else if (line_evt)
    begin
      rsh_r <= {rsh_r[8:0], tape_rdata};
      lcnt_r <= lcnt_r + 2'h1;
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      tape_wdata <= 3'h0;
      tape_write <= 1'b0;
    end
    else if (mark_evt)
      tape_write <= writing && (function_code_bits != FN_WDATA || dec_class == MK_DATA
                    || dec_class == MK_FINAL || dec_class == MK_CHECK);
    else if (line_evt)
      tape_wdata <= wbuf_r[3 * (3 - int'(lcnt_r)) +: 3];
  end

  // Outgoing word: fetched word, zero fill or check character
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      wbuf_r <= 12'h000;
    else if (brk_r == BK_XFER && brk_ack && writing)
      wbuf_r <= brk_rdata;
    else if (mark_evt && function_code_bits == FN_WDATA)
    begin
      if (dec_class == MK_CHECK)
        wbuf_r <= {par_r ^ PAR_GOOD, 6'h00};
      else if (count_overflow)
        wbuf_r <= 12'h000;
    end
  end

  // ************************************************************
  // Longitudinal checksum
  // ************************************************************
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      par_r <= 6'h00;
    else if (mark_evt && dec_class == MK_BLOCK)
      par_r <= 6'h00;
    else if (word_done && (data_cls || cls_r == MK_CHECK))
      par_r <= par_nxt;
  end

  // ************************************************************
  // Transfer requests
  // ************************************************************
  always_comb
  begin
    rd_req = 1'b0;
    if (word_done && reading)
    begin
      case (function_code_bits)
        FN_SEARCH: rd_req = cls_r == MK_BLOCK;
        FN_RDATA: rd_req = data_cls && !(count_limited_mode && count_overflow);
        FN_RALL: rd_req = 1'b1;
        default: rd_req = 1'b0;
      endcase
    end
  end

  always_comb
  begin
    wr_req = 1'b0;
    if (mark_evt)
    begin
      case (function_code_bits)
        FN_WDATA: wr_req = (dec_class == MK_DATA || dec_class == MK_FINAL) && !count_overflow;
        FN_WALL: wr_req = 1'b1;
        FN_WTM: wr_req = 1'b1;
        default: wr_req = 1'b0;
      endcase
    end
  end

  // ************************************************************
  // Three-cycle break sequencer
  // ************************************************************
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      brk_r <= BK_IDLE;
      data_request_flag <= 1'b0;
      brk_addr <= 12'h000;
      brk_incr <= 1'b0;
      brk_we <= 1'b0;
      brk_wdata <= 12'h000;
      xfer_word_r <= 12'h000;
      data_addr_r <= 12'h000;
    end
    else
    begin
      case (brk_r)
        BK_IDLE:
          if (rd_req || wr_req)
          begin
            brk_r <= BK_WC;
            data_request_flag <= 1'b1;
            brk_addr <= TRANSFER_WORD_COUNT_ADDR;
            brk_incr <= 1'b1;
            xfer_word_r <= cur_word;
          end
        BK_WC:
          if (brk_ack)
          begin
            brk_r <= BK_CA;
            brk_addr <= TRANSFER_CURRENT_ADDRESS_ADDR;
            brk_incr <= function_code_bits != FN_SEARCH;
          end
        BK_CA:
          if (brk_ack)
          begin
            brk_r <= BK_XFER;
            data_addr_r <= brk_rdata;
            brk_addr <= brk_rdata;
            brk_incr <= 1'b0;
            brk_we <= reading;
            brk_wdata <= xfer_word_r;
          end
        BK_XFER:
          if (brk_ack)
          begin
            brk_r <= BK_IDLE;
            data_request_flag <= 1'b0;
            brk_we <= 1'b0;
          end
        default:
          brk_r <= BK_IDLE;
      endcase
    end
  end

  // Overflow holds until the next status load
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      count_overflow <= 1'b0;
    else if (load_first_status_command)
      count_overflow <= 1'b0;
    else if (brk_r == BK_WC && brk_ack && brk_rdata == 12'h000)
      count_overflow <= 1'b1;
  end

  // Only the first cycle is timed; later ones follow at memory speed
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      tmo_r <= 10'h000;
    else if (brk_r == BK_WC && !brk_ack)
      tmo_r <= (tmo_r == BRK_TMO_CNT) ? tmo_r : tmo_r + 10'h001;
    else
      tmo_r <= 10'h000;
  end

  // ************************************************************
  // Done flag
  // ************************************************************
  assign xfer_end = brk_r == BK_XFER && brk_ack;

  always_comb
  begin
    done_set = 1'b0;
    case (function_code_bits)
      FN_SEARCH: done_set = xfer_end && (!count_limited_mode || count_overflow);
      FN_RDATA, FN_WDATA: done_set = word_done && cls_r == MK_CHECK
                                     && (!count_limited_mode || count_overflow);
      FN_RALL, FN_WALL, FN_WTM: done_set = xfer_end
                                           && (!count_limited_mode || count_overflow);
      default: done_set = 1'b0;
    endcase
  end

  assign done_clr = done_clear || (load_first_status_command && bus_output_lines[SRA_CLR_DONE]);

  // A set in the same cycle as a clear wins
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      operation_done_flag <= 1'b0;
    else if (done_set)
      operation_done_flag <= 1'b1;
    else if (done_clr)
      operation_done_flag <= 1'b0;
  end

  // ************************************************************
  // Error detection
  // ************************************************************
  always_comb
  begin
    err_set = '0;
    err_set[ERR_MARK] = mark_evt && !wtm_fn && dec_class == MK_BAD;
    err_set[ERR_EOT] = mark_evt && !wtm_fn && dec_class == MK_END;
    if (sel_cnt_r == 9'h001)
    begin
      err_set[ERR_SEL] = match_cnt != 4'h1
                         || (writing && write_lock[unit_sel])
                         || function_code_bits == FN_UNUSED
                         || (timing_mark_write_mode && function_code_bits != FN_WTM)
                         || (!timing_mark_write_mode && function_code_bits == FN_WTM);
    end
    err_set[ERR_PAR] = word_done && function_code_bits == FN_RDATA
                       && cls_r == MK_CHECK && par_nxt != PAR_GOOD;
    err_set[ERR_TIM] = (brk_r == BK_WC && tmo_r == BRK_TMO_CNT - 10'h001)
                       || (done_set && operation_done_flag)
                       || (load_first_status_command && in_block_r
                           && (bus_output_lines[SRA_FN_LSB +: 3] == FN_RDATA
                               || bus_output_lines[SRA_FN_LSB +: 3] == FN_WDATA));
  end

  assign err_clr = fault_clear || (load_first_status_command && bus_output_lines[SRA_CLR_ERR]);

  generate
    for (genvar g = 0; g < ERR_N; g++)
    begin : g_err
      always_ff @(posedge clk or negedge arst_n)
      begin
        if (!arst_n)
          err_r[g] <= 1'b0;
        else if (err_set[g])
          err_r[g] <= 1'b1;
        else if (err_clr)
          err_r[g] <= 1'b0;
      end
    end
  endgenerate

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      fault_flag <= 1'b0;
    else if (|err_set)
      fault_flag <= 1'b1;
    else if (err_clr)
      fault_flag <= 1'b0;
  end

  assign mark_err = err_r[ERR_MARK];
  assign eot_err = err_r[ERR_EOT];
  assign sel_err = err_r[ERR_SEL];
  assign par_err = err_r[ERR_PAR];
  assign tim_err = err_r[ERR_TIM];

  // ************************************************************
  // Interrupt request
  // ************************************************************
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      irq <= 1'b0;
    else
      irq <= ie_r && (operation_done_flag || fault_flag);
  end
endmodule
`default_nettype wire

// ### tape_ctl_asserts.sv
`default_nettype none
module tape_ctl_asserts
  import tape_ctl_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic load_first_status_command,
  input wire logic brk_ack,
  input wire logic tape_go,
  input wire logic data_request_flag,
  input wire logic [11:0] brk_addr,
  input wire logic brk_incr,
  input wire logic operation_done_flag,
  input wire logic fault_flag,
  input wire logic mark_err,
  input wire logic eot_err,
  input wire logic sel_err,
  input wire logic par_err,
  input wire logic tim_err,
  input wire logic irq
);
  timeunit 1ns;
  timeprecision 1ps;
  // ********************
  // Helpers
  // ********************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  logic [9:0] wait_r;
  logic hard;
  // Parity is left out: it must not stop the tape
  assign hard = mark_err | eot_err | sel_err | tim_err;
  always_ff @(posedge clk or negedge arst_n)
    if (!arst_n)
      wait_r <= 10'h000;
    else if (!data_request_flag || brk_ack)
      wait_r <= 10'h000;
    else if (wait_r != 10'h3FF)
      wait_r <= wait_r + 10'h001;
  // ********************
  // Properties
  // ********************
  property p_sel_dly;
    $rose(sel_err) |-> $past(load_first_status_command, 251);
  endproperty
  a_sel_dly: assert property (p_sel_dly) else $error("select fault off delay");
  property p_halt;
    $rose(hard) |-> !tape_go;
  endproperty
  a_halt: assert property (p_halt) else $error("tape kept running");
  property p_par_run;
    $rose(par_err) && !$rose(hard) && !$past(load_first_status_command)
      |-> tape_go == $past(tape_go);
  endproperty
  a_par_run: assert property (p_par_run) else $error("parity moved tape");
  property p_fault;
    $rose(hard | par_err) |-> ##[0:1] fault_flag;
  endproperty
  a_fault: assert property (p_fault) else $error("fault flag missing");
  property p_irq;
    irq |-> $past(operation_done_flag | fault_flag);
  endproperty
  a_irq: assert property (p_irq) else $error("irq without cause");
  property p_req_wc;
    $rose(data_request_flag) |-> brk_addr == TRANSFER_WORD_COUNT_ADDR && brk_incr;
  endproperty
  a_req_wc: assert property (p_req_wc) else $error("count cycle wrong");
  property p_req_ca;
    data_request_flag && brk_ack && brk_addr == TRANSFER_WORD_COUNT_ADDR
      |=> brk_addr == TRANSFER_CURRENT_ADDRESS_ADDR;
  endproperty
  a_req_ca: assert property (p_req_ca) else $error("address cycle wrong");
  property p_req_hold;
    data_request_flag && !brk_ack |=> data_request_flag && $stable(brk_addr);
  endproperty
  a_req_hold: assert property (p_req_hold) else $error("request dropped");
  property p_tmo;
    wait_r == 10'h35C |-> tim_err;
  endproperty
  a_tmo: assert property (p_tmo) else $error("late break unflagged");
  c_done: cover property ($rose(operation_done_flag));
  c_sel: cover property ($rose(sel_err));
  c_par: cover property ($rose(par_err));
  c_tmo: cover property (wait_r == 10'h35C);
endmodule
bind tape_block_transfer_control tape_ctl_asserts u_chk (.*);
`default_nettype wire

// ### tape_break_mem.sv
`default_nettype none
module tape_break_mem
  import tape_ctl_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic data_request_flag,
  input wire logic [11:0] brk_addr,
  input wire logic brk_incr,
  input wire logic brk_we,
  input wire logic [11:0] brk_wdata,
  input wire logic [9:0] dly,
  output logic brk_ack,
  output logic [11:0] brk_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  // ********************
  // Field 0 memory
  // ********************
  logic [11:0] mem [4096];
  logic [11:0] rd_r;
  logic [9:0] cnt_r;
  // Stale data is inverted so it never passes for a fresh answer
  assign brk_rdata = brk_ack ? rd_r : ~rd_r;
  always @(posedge clk or negedge arst_n)
    if (!arst_n)
    begin
      brk_ack <= 1'h0;
      cnt_r <= 10'h000;
      rd_r <= 12'h000;
    end
    else if (brk_ack || !data_request_flag)
    begin
      brk_ack <= 1'h0;
      cnt_r <= 10'h000;
    end
    else if (cnt_r < dly)
      cnt_r <= cnt_r + 10'h001;
    else
    begin
      brk_ack <= 1'h1;
      rd_r <= mem[brk_addr] + 12'(brk_incr);
      if (brk_incr)
        mem[brk_addr] <= mem[brk_addr] + 12'h001;
      if (brk_we)
        mem[brk_addr] <= brk_wdata;
    end
endmodule
`default_nettype wire

// ### tape_block_transfer_control_tb_top.sv
`default_nettype none
module tape_block_transfer_control_tb_top
  import tape_ctl_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  // ********************
  // Bench
  // ********************
  typedef struct {logic [11:0] w; logic [7:0] um, wl; logic sw, se;} row_s;
  row_s rows [10] = '{'{12'hB80, 8'h01, 8'h00, 1'h0, 1'h0}, '{12'h080, 8'h00, 8'h00, 1'h0, 1'h1},
    '{12'h080, 8'h05, 8'h00, 1'h0, 1'h1}, '{12'h0A0, 8'h01, 8'h01, 1'h0, 1'h1},
    '{12'h0A8, 8'h01, 8'h01, 1'h0, 1'h1}, '{12'h0B8, 8'h01, 8'h00, 1'h0, 1'h1},
    '{12'h0B0, 8'h01, 8'h00, 1'h0, 1'h1}, '{12'h0B0, 8'h01, 8'h00, 1'h1, 1'h0},
    '{12'h088, 8'h01, 8'h00, 1'h1, 1'h1}, '{12'h098, 8'h01, 8'h01, 1'h0, 1'h0}};
  logic clk = 1'h0, arst_n = 1'h0, load_first_status_command = 1'h0, done_clear = 1'h0;
  logic fault_clear = 1'h0, timing_mark_write_mode = 1'h0, mark_stb = 1'h0, line_stb = 1'h0;
  logic [11:0] bus_output_lines = 12'h000, brk_rdata, brk_addr, brk_wdata, wd;
  logic [7:0] unit_match = 8'h01, write_lock = 8'h00;
  logic [5:0] mark_code = 6'h00;
  logic [2:0] tape_rdata = 3'h0, unit_sel, tape_wdata;
  logic tape_go, tape_rev, tape_write, timing_track_out, data_request_flag, brk_incr, brk_we;
  logic brk_ack, operation_done_flag, fault_flag, mark_err, eot_err, sel_err, par_err, tim_err;
  logic count_limited_mode, irq;
  logic [9:0] dly = 10'h001;
  int miscompares = 0, samples_checked = 0;
  tape_block_transfer_control dut (.*);
  tape_break_mem u_mem (.*);
  always #10 clk = ~clk;
  task automatic close_out;
    if (miscompares == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [11:0] g, input logic [11:0] e);
    samples_checked++;
    if (g !== e)
    begin
      miscompares++;
      $display("unexpected at %0t: got %h exp %h", $time, g, e);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic rst;
    arst_n = 1'h0;
    idle(2);
    arst_n = 1'h1;
    idle(1);
  endtask
  task automatic ld(input logic [11:0] w);
    bus_output_lines = w;
    load_first_status_command = 1'h1;
    @(negedge clk) load_first_status_command = 1'h0;
  endtask
  task automatic clr;
    done_clear = 1'h1;
    fault_clear = 1'h1;
    @(negedge clk) done_clear = 1'h0;
    fault_clear = 1'h0;
  endtask
  task automatic wreq;
    int n = 0;
    while (data_request_flag !== 1'h0 && n < 300)
    begin
      idle(1);
      n++;
    end
    if (n == 300)
    begin
      miscompares++;
      close_out;
    end
    idle(2);
  endtask
  // Slot: one mark, then four lines first-character-high
  task automatic slot(input logic [5:0] c, input logic [11:0] w, input logic wt);
    mark_code = c;
    mark_stb = 1'h1;
    @(negedge clk) mark_stb = 1'h0;
    for (int i = 0; i < 4; i++)
    begin
      idle(16);
      tape_rdata = w[11 - 3 * i -: 3];
      line_stb = 1'h1;
      @(negedge clk) line_stb = 1'h0;
      idle(3);
      wd[11 - 3 * i -: 3] = tape_wdata;
    end
    if (wt)
      wreq;
  endtask
  initial
  begin
    #400000;
    miscompares++;
    close_out;
  end
  initial
  begin
    idle(2);
    chk(12'({irq, tape_go, data_request_flag, operation_done_flag, fault_flag}), 12'h000);
    arst_n = 1'h1;
    u_mem.mem[12'hFEC] = 12'h800;
    foreach (rows[i])
    begin
      unit_match = rows[i].um;
      write_lock = rows[i].wl;
      timing_mark_write_mode = rows[i].sw;
      rst;
      ld(rows[i].w);
      idle(251);
      chk(12'({sel_err, fault_flag, tape_go, unit_sel, tape_rev}),
          12'({rows[i].se, rows[i].se, !rows[i].se, rows[i].w[11:8]}));
    end
    unit_match = 8'h01;
    write_lock = 8'h00;
    timing_mark_write_mode = 1'h0;
    rst;
    u_mem.mem[12'hFED] = 12'h100;
    ld(12'h09C);
    slot(6'h04, 12'hA5C, 1'h1);
    chk(u_mem.mem[12'h101], 12'hA5C);
    chk(u_mem.mem[12'hFED], 12'h101);
    chk(12'({operation_done_flag, irq, tim_err}), 12'h006);
    slot(6'h04, 12'h000, 1'h1);
    chk(12'({tim_err, tape_go}), 12'h002);
    clr;
    ld(12'h098);
    slot(6'h04, 12'h123, 1'h1);
    chk(12'({operation_done_flag, irq}), 12'h002);
    clr;
    u_mem.mem[12'hFED] = 12'h1FF;
    u_mem.mem[12'h200] = 12'h6B1;
    ld(12'h0A8);
    slot(6'h04, 12'h000, 1'h1);
    chk(wd, 12'h6B1);
    chk(12'({operation_done_flag, tape_write}), 12'h003);
    clr;
    u_mem.mem[12'hFEC] = 12'hFFE;
    u_mem.mem[12'hFED] = 12'h300;
    ld(12'h0C8);
    slot(6'h02, 12'h017, 1'h1);
    chk(12'({count_limited_mode, operation_done_flag}), 12'h002);
    chk(u_mem.mem[12'h300], 12'h017);
    slot(6'h02, 12'h018, 1'h1);
    chk(u_mem.mem[12'h300], 12'h018);
    chk(12'({operation_done_flag, u_mem.mem[12'hFED]}), 12'h300);
    chk(12'(operation_done_flag), 12'h001);
    clr;
    ld(12'h088);
    slot(6'h02, 12'h019, 1'h1);
    chk(12'(operation_done_flag), 12'h001);
    clr;
    ld(12'h080);
    slot(6'h3F, 12'h000, 1'h1);
    chk(12'({mark_err, tape_go}), 12'h001);
    slot(6'h01, 12'h000, 1'h1);
    chk(12'({eot_err, fault_flag, tape_go}), 12'h006);
    clr;
    ld(12'h088);
    slot(6'h3F, 12'h000, 1'h1);
    chk(12'({mark_err, fault_flag, tape_go}), 12'h006);
    clr;
    u_mem.mem[12'hFED] = 12'h3FF;
    ld(12'h090);
    slot(6'h04, 12'h000, 1'h1);
    slot(6'h06, 12'h000, 1'h1);
    chk(12'({par_err, fault_flag, tape_go, operation_done_flag}), 12'h00F);
    ld(12'h090);
    idle(3);
    chk(12'(tim_err), 12'h001);
    timing_mark_write_mode = 1'h1;
    rst;
    ld(12'h0B0);
    idle(LINE_CYC + 2);
    chk(12'(timing_track_out), 12'h001);
    timing_mark_write_mode = 1'h0;
    rst;
    u_mem.mem[12'hFED] = 12'h100;
    ld(12'h0A0);
    slot(6'h04, 12'h000, 1'h1);
    chk(wd, 12'hA5C);
    slot(6'h06, 12'h000, 1'h1);
    chk(wd, 12'h280);
    chk(12'(operation_done_flag), 12'h001);
    rst;
    dly = 10'h384;
    ld(12'h09C);
    slot(6'h04, 12'h000, 1'h0);
    idle(880);
    chk(12'(tim_err), 12'h001);
    dly = 10'h001;
    wreq;
    close_out;
  end
endmodule
`default_nettype wire
